// File: mac_pkg.sv
// Constants and types of the multiplier and accumulator mode control
// How it works
// - Sign extend makes 17x17 product, top dropped
// - Sign extension also used for string multiplies
// - Unsigned mode zeroes multiplier seventeenth bit only when fraction mode is off
// - Signed mode copies multiplier bit 15 upward
// - Load unsigned also sets the unsigned bit
// - Product low to accumulator, high to product register
// - Saturating overflow sets flag, clamps by direction
// - String overflow clamps only the top word
// - Without saturation the wrapped result is written
// - Logical operations never overflow or saturate
// - Fraction mode shifts multiplier left one bit
// - Fraction shift also used for string multiplies
// - Mode bits sit at status bits zero to three
// - Modes set by status write or set/clear; unsigned by status write or load unsigned
package mac_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] OFS_STATUS       = 8'h00;
  localparam logic [7:0] OFS_EVENT        = 8'h04;
  localparam logic [7:0] OFS_MASK         = 8'h08;
  localparam logic [7:0] OFS_PRODUCT_HIGH = 8'h0C;
  localparam logic [7:0] OFS_MULT_OPERAND = 8'h10;

  // Status word field positions
  localparam int BIT_SIGN_EXTEND = 0;
  localparam int BIT_UNSIGNED    = 1;
  localparam int BIT_SATURATE    = 2;
  localparam int BIT_FRACTION    = 3;
  localparam int BIT_OVERFLOW    = 4;

  // Event register bit positions
  localparam int EV_OVERFLOW = 0;
  localparam int EV_SATURATE = 1;

  // Reset values
  localparam logic [3:0]  MODE_RST    = 4'h0;
  localparam logic [1:0]  EVENT_RST   = 2'h0;
  localparam logic [1:0]  MASK_RST    = 2'h0;
  localparam logic [15:0] WORD_RST    = 16'h0000;
  localparam logic [31:0] RDDATA_RST  = 32'h0000_0000;

  // Saturation limits of one accumulator word
  localparam logic [15:0] SAT_POS = 16'h7FFF;
  localparam logic [15:0] SAT_NEG = 16'h8000;

  typedef enum logic [3:0] {
    OP_NONE, OP_MULTIPLY, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR,
    OP_LOAD_MULT, OP_LOAD_UNSIGNED, OP_SET_MODE, OP_CLEAR_MODE
  } mac_op_t;

  typedef enum logic [1:0] {
    SEL_SIGN_EXTEND, SEL_UNSIGNED, SEL_SATURATE, SEL_FRACTION
  } mac_sel_t;

  typedef struct packed {
    logic fraction;
    logic saturate;
    logic unsignedMult;
    logic signExtend;
  } mac_mode_t;

  typedef struct packed {
    logic        valid;
    mac_op_t     op;
    mac_sel_t    sel;
    logic        isString;
    logic        isFirst;
    logic        isMsw;
    logic [15:0] accA;
    logic [15:0] accB;
  } mac_instr_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } mac_acc_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } mac_bus_t;

endpackage

// File: mac_mult_path.sv
// Operand extension and 17 by 17 multiplier
`timescale 1ns/10ps
module mac_mult_path (
  // Mode and operands
  input  wire mac_pkg::mac_mode_t mode,
  input  wire logic               topWord,
  input  wire logic [15:0]        multiplicand,
  input  wire logic [15:0]        multOperand,
  // Product halves
  output logic [15:0]             productLow,
  output logic [15:0]             productHigh
);
  logic signed [16:0] mcand;
  logic signed [16:0] mplier;
  logic signed [33:0] prod;

  always_comb begin
    // Only the top word of a string carries the sign
    mcand = {mode.signExtend & topWord & multiplicand[15], multiplicand};
    if (mode.fraction) begin
      mplier = {multOperand, 1'b0};
    end else begin
      mplier = {~mode.unsignedMult & multOperand[15], multOperand};
    end
    prod        = mcand * mplier;
    // Two top sign bits of the 34-bit product dropped
    productLow  = prod[15:0];
    productHigh = prod[31:16];
  end
endmodule

// File: mac_add_path.sv
// Add, subtract and logic word path with saturation
`timescale 1ns/10ps
module mac_add_path (
  // Operation and operands
  input  wire mac_pkg::mac_op_t op,
  input  wire logic             saturate,
  input  wire logic             topWord,
  input  wire logic             carryIn,
  input  wire logic [15:0]      a,
  input  wire logic [15:0]      b,
  // Result
  output logic [15:0]           result,
  output logic                  carryOut,
  output logic                  overflow,
  output logic                  saturated
);
  logic [15:0] bb;
  logic [16:0] sum;
  logic        arith;

  always_comb begin
    arith     = (op == mac_pkg::OP_ADD) || (op == mac_pkg::OP_SUB);
    bb        = (op == mac_pkg::OP_SUB) ? ~b : b;
    sum       = {1'b0, a} + {1'b0, bb} + {16'h0000, carryIn};
    // Logic operations can never overflow
    overflow  = arith && topWord && (a[15] == bb[15]) && (sum[15] != a[15]);
    saturated = overflow && saturate;
    carryOut  = arith ? sum[16] : 1'b0;
    unique case (op)
      mac_pkg::OP_AND: result = a & b;
      mac_pkg::OP_OR:  result = a | b;
      mac_pkg::OP_XOR: result = a ^ b;
      default:         result = sum[15:0];
    endcase
    // Clamp only the top word; lower string words keep their sum
    if (saturated) begin
      result = a[15] ? mac_pkg::SAT_NEG : mac_pkg::SAT_POS;
    end
  end
endmodule

// File: mac_mode_ctrl.sv
// Mode control of the multiplier and accumulator datapath
`timescale 1ns/10ps
module mac_mode_ctrl (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  // Instruction from the decoder
  input  wire mac_pkg::mac_instr_t instr,
  // Register port
  input  wire mac_pkg::mac_bus_t   bus,
  output logic [31:0]              rdData,
  // Accumulator and product results
  output mac_pkg::mac_acc_t        accOut,
  output logic [15:0]              productHigh,
  output logic                     carryOut,
  // Status and interrupt
  output logic [4:0]               statusWord,
  output logic                     irq
);

  typedef struct packed {
    mac_pkg::mac_mode_t mode;
    logic               overflowFlag;
    logic [1:0]         events;
    logic [1:0]         mask;
    logic [15:0]        multOperand;
    logic [15:0]        productHigh;
    logic               carry;
    mac_pkg::mac_acc_t  acc;
    logic [31:0]        rdData;
    logic               irq;
  } mac_state_t;

  mac_state_t  s;
  mac_state_t  next_s;

  logic [15:0] multLow;
  logic [15:0] multHigh;
  logic [15:0] addResult;
  logic        addCarry;
  logic        addOverflow;
  logic        addSaturated;
  logic        carryIn;

  // Set or clear one mode bit; the unsigned bit is left unchanged
  function automatic mac_pkg::mac_mode_t apply_sel(input mac_pkg::mac_mode_t m,
                                                   input mac_pkg::mac_sel_t sel,
                                                   input logic val);
    mac_pkg::mac_mode_t r;
    r = m;
    unique case (sel)
      mac_pkg::SEL_SIGN_EXTEND: r.signExtend = val;
      mac_pkg::SEL_UNSIGNED:    r.unsignedMult = m.unsignedMult;
      mac_pkg::SEL_SATURATE:    r.saturate = val;
      mac_pkg::SEL_FRACTION:    r.fraction = val;
    endcase
    return r;
  endfunction

  // Carry in: fresh for single words and first string words
  assign carryIn = (instr.isString && !instr.isFirst) ? s.carry : (instr.op == mac_pkg::OP_SUB);

  mac_mult_path u_mult (
    .mode         (s.mode),
    .topWord      (instr.isMsw),
    .multiplicand (instr.accA),
    .multOperand  (s.multOperand),
    .productLow   (multLow),
    .productHigh  (multHigh)
  );

  mac_add_path u_add (
    .op        (instr.op),
    .saturate  (s.mode.saturate),
    .topWord   (instr.isMsw),
    .carryIn   (carryIn),
    .a         (instr.accA),
    .b         (instr.accB),
    .result    (addResult),
    .carryOut  (addCarry),
    .overflow  (addOverflow),
    .saturated (addSaturated)
  );

  always_comb begin
    next_s            = s;
    next_s.acc.valid  = 1'b0;
    next_s.rdData     = mac_pkg::RDDATA_RST;

    // Register writes
    if (bus.wr) begin
      unique case (bus.addr)
        mac_pkg::OFS_STATUS: begin
          next_s.mode         = bus.wdata[mac_pkg::BIT_FRACTION:mac_pkg::BIT_SIGN_EXTEND];
          next_s.overflowFlag = bus.wdata[mac_pkg::BIT_OVERFLOW];
        end
        mac_pkg::OFS_MASK:         next_s.mask = bus.wdata[1:0];
        mac_pkg::OFS_MULT_OPERAND: next_s.multOperand = bus.wdata[15:0];
        default: ;
      endcase
    end

    // Register reads, data in the following cycle
    if (bus.rd) begin
      unique case (bus.addr)
        mac_pkg::OFS_STATUS:       next_s.rdData = {27'h000_0000, s.overflowFlag, s.mode};
        mac_pkg::OFS_EVENT: begin
          next_s.rdData = {30'h0000_0000, s.events};
          next_s.events = mac_pkg::EVENT_RST;
        end
        mac_pkg::OFS_MASK:         next_s.rdData = {30'h0000_0000, s.mask};
        mac_pkg::OFS_PRODUCT_HIGH: next_s.rdData = {16'h0000, s.productHigh};
        mac_pkg::OFS_MULT_OPERAND: next_s.rdData = {16'h0000, s.multOperand};
        default:                   next_s.rdData = mac_pkg::RDDATA_RST;
      endcase
    end

    // Instructions act after bus writes, so hardware sets win
    if (instr.valid) begin
      unique case (instr.op)
        mac_pkg::OP_MULTIPLY: begin
          next_s.acc.valid   = 1'b1;
          next_s.acc.data    = multLow;
          next_s.productHigh = multHigh;
        end
        mac_pkg::OP_ADD, mac_pkg::OP_SUB, mac_pkg::OP_AND, mac_pkg::OP_OR, mac_pkg::OP_XOR: begin
          next_s.acc.valid = 1'b1;
          next_s.acc.data  = addResult;
          next_s.carry     = addCarry;
          if (addOverflow) begin
            next_s.overflowFlag                = 1'b1;
            next_s.events[mac_pkg::EV_OVERFLOW] = 1'b1;
          end
          if (addSaturated) begin
            next_s.events[mac_pkg::EV_SATURATE] = 1'b1;
          end
        end
        mac_pkg::OP_LOAD_MULT: next_s.multOperand = instr.accA;
        mac_pkg::OP_LOAD_UNSIGNED: begin
          next_s.multOperand       = instr.accA;
          next_s.mode.unsignedMult = 1'b1;
        end
        // Registered modes reach the next instruction, not this one
        mac_pkg::OP_SET_MODE:   next_s.mode = apply_sel(s.mode, instr.sel, 1'b1);
        mac_pkg::OP_CLEAR_MODE: next_s.mode = apply_sel(s.mode, instr.sel, 1'b0);
        default: ;
      endcase
    end

    next_s.irq = |(next_s.events & next_s.mask);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s.mode         <= mac_pkg::MODE_RST;
      s.overflowFlag <= 1'b0;
      s.events       <= mac_pkg::EVENT_RST;
      s.mask         <= mac_pkg::MASK_RST;
      s.multOperand  <= mac_pkg::WORD_RST;
      s.productHigh  <= mac_pkg::WORD_RST;
      s.carry        <= 1'b0;
      s.acc          <= '0;
      s.rdData       <= mac_pkg::RDDATA_RST;
      s.irq          <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign rdData      = s.rdData;
  assign accOut      = s.acc;
  assign productHigh = s.productHigh;
  assign carryOut    = s.carry;
  assign statusWord  = {s.overflowFlag, s.mode};
  assign irq         = s.irq;

  // Checks
  logic mulGo;
  logic arithGo;
  assign mulGo   = instr.valid && (instr.op == mac_pkg::OP_MULTIPLY) && !instr.isString;
  assign arithGo = instr.valid && !instr.isString && instr.isMsw
                   && ((instr.op == mac_pkg::OP_ADD) || (instr.op == mac_pkg::OP_SUB));

  property p_sign_extend;
    @(posedge ref_clk) disable iff (!nrst)
    mulGo && instr.isMsw && s.mode.signExtend && !s.mode.unsignedMult && !s.mode.fraction
      && instr.accA == 16'h8000 && s.multOperand == 16'h8000
    |=> productHigh == 16'h4000 && accOut.data == 16'h0000 && accOut.valid;
  endproperty
  a_sign_extend: assert property (p_sign_extend) else $error("signed product wrong");

  property p_unsigned;
    @(posedge ref_clk) disable iff (!nrst)
    mulGo && s.mode.unsignedMult && !s.mode.fraction && instr.accA == 16'h0080
    |=> productHigh == {9'h000, $past(s.multOperand[15:9])};
  endproperty
  a_unsigned: assert property (p_unsigned) else $error("unsigned product wrong");

  property p_signed_mult;
    @(posedge ref_clk) disable iff (!nrst)
    mulGo && !s.mode.unsignedMult && !s.mode.fraction && instr.accA == 16'h0001
    |=> productHigh == {16{$past(s.multOperand[15])}} && accOut.data == $past(s.multOperand);
  endproperty
  a_signed_mult: assert property (p_signed_mult) else $error("signed multiplier wrong");

  property p_load_unsigned;
    @(posedge ref_clk) disable iff (!nrst)
    instr.valid && instr.op == mac_pkg::OP_LOAD_UNSIGNED
    |=> statusWord[mac_pkg::BIT_UNSIGNED] && s.multOperand == $past(instr.accA);
  endproperty
  a_load_unsigned: assert property (p_load_unsigned) else $error("load unsigned missed");

  property p_mult_zero;
    @(posedge ref_clk) disable iff (!nrst)
    mulGo && instr.accA == 16'h0000 |=> accOut.valid && accOut.data == 16'h0000 && productHigh == 16'h0000;
  endproperty
  a_mult_zero: assert property (p_mult_zero) else $error("product halves wrong");

  property p_saturate;
    @(posedge ref_clk) disable iff (!nrst)
    arithGo && s.mode.saturate && instr.op == mac_pkg::OP_ADD && instr.accA == 16'h7FFE && instr.accB == 16'h0005
    |=> accOut.valid && accOut.data == 16'h7FFF && statusWord[mac_pkg::BIT_OVERFLOW];
  endproperty
  a_saturate: assert property (p_saturate) else $error("saturation wrong");

  property p_wrap;
    @(posedge ref_clk) disable iff (!nrst)
    arithGo && !s.mode.saturate && instr.op == mac_pkg::OP_ADD
    |=> accOut.data == $past(instr.accA + instr.accB);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrapped sum wrong");

  property p_logic_no_ovf;
    @(posedge ref_clk) disable iff (!nrst)
    instr.valid && !bus.wr && (instr.op == mac_pkg::OP_AND || instr.op == mac_pkg::OP_OR || instr.op == mac_pkg::OP_XOR)
    |=> $stable(statusWord[mac_pkg::BIT_OVERFLOW])
      && accOut.data == (($past(instr.op) == mac_pkg::OP_AND) ? $past(instr.accA & instr.accB)
                       : ($past(instr.op) == mac_pkg::OP_OR) ? $past(instr.accA | instr.accB)
                       : $past(instr.accA ^ instr.accB));
  endproperty
  a_logic_no_ovf: assert property (p_logic_no_ovf) else $error("logic op overflowed");

  property p_fraction;
    @(posedge ref_clk) disable iff (!nrst)
    mulGo && s.mode.fraction |=> accOut.data[0] == 1'b0;
  endproperty
  a_fraction: assert property (p_fraction) else $error("fraction shift missing");

  property p_no_unsigned_set;
    @(posedge ref_clk) disable iff (!nrst)
    instr.valid && !bus.wr && instr.sel == mac_pkg::SEL_UNSIGNED
      && (instr.op == mac_pkg::OP_SET_MODE || instr.op == mac_pkg::OP_CLEAR_MODE)
    |=> $stable(statusWord[mac_pkg::BIT_UNSIGNED]);
  endproperty
  a_no_unsigned_set: assert property (p_no_unsigned_set) else $error("unsigned changed by set");

  property p_mode_clear;
    @(posedge ref_clk) disable iff (!nrst)
    instr.valid && !bus.wr && instr.op == mac_pkg::OP_CLEAR_MODE && instr.sel == mac_pkg::SEL_FRACTION
    |=> !statusWord[mac_pkg::BIT_FRACTION];
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("mode clear missed");

  property p_mode_next;
    @(posedge ref_clk) disable iff (!nrst)
    instr.valid && !bus.wr && instr.op == mac_pkg::OP_SET_MODE && instr.sel == mac_pkg::SEL_FRACTION
    |=> statusWord[mac_pkg::BIT_FRACTION];
  endproperty
  a_mode_next: assert property (p_mode_next) else $error("mode set missed");

  property p_status_write;
    @(posedge ref_clk) disable iff (!nrst)
    bus.wr && bus.addr == mac_pkg::OFS_STATUS && !instr.valid
    |=> statusWord == $past(bus.wdata[4:0]);
  endproperty
  a_status_write: assert property (p_status_write) else $error("status write wrong");

  property p_string_sign;
    @(posedge ref_clk) disable iff (!nrst)
    instr.valid && instr.op == mac_pkg::OP_MULTIPLY && instr.isString && instr.isMsw
      && s.mode.signExtend && !s.mode.unsignedMult && !s.mode.fraction
      && instr.accA == 16'h8000 && s.multOperand == 16'h8000
    |=> accOut.valid && productHigh == 16'h4000;
  endproperty
  a_string_sign: assert property (p_string_sign) else $error("string sign extension wrong");

  property p_string_frac;
    @(posedge ref_clk) disable iff (!nrst)
    instr.valid && instr.op == mac_pkg::OP_MULTIPLY && instr.isString && s.mode.fraction
    |=> accOut.valid && accOut.data[0] == 1'b0;
  endproperty
  a_string_frac: assert property (p_string_frac) else $error("string fraction shift missing");

  property p_ovf_flag;
    @(posedge ref_clk) disable iff (!nrst)
    instr.valid && addOverflow |=> statusWord[mac_pkg::BIT_OVERFLOW];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag missed");

  property p_string_low;
    @(posedge ref_clk) disable iff (!nrst)
    instr.valid && instr.op == mac_pkg::OP_ADD && instr.isString && instr.isFirst && !instr.isMsw
    |=> accOut.valid && accOut.data == $past(16'(instr.accA + instr.accB));
  endproperty
  a_string_low: assert property (p_string_low) else $error("lower string word changed");

  property p_string_sat;
    @(posedge ref_clk) disable iff (!nrst)
    instr.valid && instr.isString && instr.isMsw && s.mode.saturate && addOverflow
    |=> accOut.data == ($past(instr.accA[15]) ? mac_pkg::SAT_NEG : mac_pkg::SAT_POS)
      && statusWord[mac_pkg::BIT_OVERFLOW];
  endproperty
  a_string_sat: assert property (p_string_sat) else $error("string top word not clamped");

endmodule

// File: mac_acc_file.sv
// Accumulator register file model fed by the block's result words
`timescale 1ns/10ps
module mac_acc_file (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // Result words from the block
  input  wire mac_pkg::mac_acc_t accOut,
  // Stored state
  output logic [15:0]            lastWord,
  output int                     wordCnt
);
  // Each result pulse is stored in lastWord and counted once
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lastWord <= 16'h0000;
      wordCnt  <= 0;
    end else if (accOut.valid === 1'b1) begin
      lastWord <= accOut.data;
      wordCnt  <= wordCnt + 1;
    end
  end
endmodule

// File: test_multiplier_accumulator_modes.sv
// Testbench of the multiplier and accumulator mode control
`timescale 1ns/10ps
module test_multiplier_accumulator_modes;
  typedef struct packed {
    logic        chkPh;
    logic [15:0] acc;
    logic [15:0] ph;
  } mac_exp_t;

  localparam logic [2:0] ONE = 3'h1;
  localparam logic [2:0] LO  = 3'h6;
  localparam logic [2:0] HI  = 3'h5;

  logic                ref_clk;
  logic                nrst;
  mac_pkg::mac_instr_t instr;
  mac_pkg::mac_bus_t   bus;
  logic [31:0]         rdData;
  mac_pkg::mac_acc_t   accOut;
  logic [15:0]         productHigh;
  logic [4:0]          statusWord;
  logic                irq;
  logic [15:0]         lastWord;
  logic [15:0]         lastExp;
  logic [15:0]         ra;
  logic [15:0]         rb;
  logic [16:0]         rs;
  logic                carryOut;
  int                  wordCnt;
  int                  errorCnt;
  int                  checks;
  int                  cycles;
  int                  seed;
  int                  pushed;
  mac_exp_t            expQ[$];
  mac_exp_t            e;
  logic [7:0]          ofs[5] = '{mac_pkg::OFS_STATUS, mac_pkg::OFS_EVENT, mac_pkg::OFS_MASK,
                                  mac_pkg::OFS_PRODUCT_HIGH, mac_pkg::OFS_MULT_OPERAND};

  mac_mode_ctrl u_mac_mode_ctrl (
    .ref_clk     (ref_clk),
    .nrst        (nrst),
    .instr       (instr),
    .bus         (bus),
    .rdData      (rdData),
    .accOut      (accOut),
    .productHigh (productHigh),
    .carryOut    (carryOut),
    .statusWord  (statusWord),
    .irq         (irq)
  );

  mac_acc_file u_mac_acc_file (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .accOut   (accOut),
    .lastWord (lastWord),
    .wordCnt  (wordCnt)
  );

  task automatic testDone;
    $display("checks %0d errors %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic op(input mac_pkg::mac_op_t o, input logic [15:0] a, input logic [15:0] b,
                    input logic [2:0] flg, input mac_pkg::mac_sel_t sel);
    mac_pkg::mac_instr_t t;
    t = '{1'b1, o, sel, flg[2], flg[1], flg[0], a, b};
    @(posedge ref_clk);
    instr <= t;
  endtask

  task automatic idle;
    @(posedge ref_clk);
    instr.valid <= 1'b0;
  endtask

  task automatic md(input mac_pkg::mac_op_t o, input mac_pkg::mac_sel_t sel);
    op(o, 16'h0000, 16'h0000, ONE, sel);
  endtask

  task automatic note(input logic c, input logic [15:0] lo, input logic [15:0] hi);
    expQ.push_back('{c, lo, hi});
    pushed++;
    lastExp = lo;
  endtask

  task automatic mul(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    op(mac_pkg::OP_MULTIPLY, a, 16'h0000, ONE, mac_pkg::SEL_SIGN_EXTEND);
    note(1'b1, lo, hi);
  endtask

  task automatic add(input mac_pkg::mac_op_t o, input logic [15:0] a, input logic [15:0] b,
                     input logic [2:0] flg, input logic [15:0] r);
    op(o, a, b, flg, mac_pkg::SEL_SIGN_EXTEND);
    note(1'b0, r, 16'h0000);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(negedge ref_clk);
    chk(rdData, exp);
  endtask

  task automatic sts(input logic [4:0] x);
    @(negedge ref_clk);
    chk({27'h0, statusWord}, {27'h0, x});
  endtask

  // Result watcher: each pulse takes the oldest expectation
  always @(negedge ref_clk) begin
    if (accOut.valid === 1'b1) begin
      if (expQ.size() == 0) begin
        errorCnt++;
        $display("[FAIL] %0t got %h expected %h", $time, accOut.data, 16'h0000);
      end else begin
        e = expQ.pop_front();
        chk({16'h0000, accOut.data}, {16'h0000, e.acc});
        if (e.chkPh)
          chk({16'h0000, productHigh}, {16'h0000, e.ph});
      end
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errorCnt++;
      testDone;
    end
  end

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    nrst = 1'b0;
    instr = '0;
    bus = '0;
    seed = 27;
    errorCnt = 0;
    checks = 0;
    cycles = 0;
    pushed = 0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (ofs[i]) rd(ofs[i], 32'h0000_0000);
    wr(mac_pkg::OFS_STATUS, 32'h0000_0001);
    rd(mac_pkg::OFS_STATUS, 32'h0000_0001);
    op(mac_pkg::OP_LOAD_MULT, 16'h8000, 16'h0000, ONE, mac_pkg::SEL_SIGN_EXTEND);
    mul(16'h8000, 16'h0000, 16'h4000);
    op(mac_pkg::OP_LOAD_UNSIGNED, 16'h8000, 16'h0000, ONE, mac_pkg::SEL_SIGN_EXTEND);
    mul(16'h0080, 16'h0000, 16'h0040);
    idle;
    sts(5'h03);
    wr(mac_pkg::OFS_STATUS, 32'h0000_0001);
    mul(16'h0080, 16'h0000, 16'hFFC0);
    mul(16'h0001, 16'h8000, 16'hFFFF);
    mul(16'h0000, 16'h0000, 16'h0000);
    op(mac_pkg::OP_MULTIPLY, 16'h8000, 16'h0000, LO, mac_pkg::SEL_SIGN_EXTEND);
    note(1'b1, 16'h0000, 16'hC000);
    op(mac_pkg::OP_MULTIPLY, 16'h8000, 16'h0000, HI, mac_pkg::SEL_SIGN_EXTEND);
    note(1'b1, 16'h0000, 16'h4000);
    op(mac_pkg::OP_LOAD_MULT, 16'h7FFF, 16'h0000, ONE, mac_pkg::SEL_SIGN_EXTEND);
    mul(16'h7FFF, 16'h0001, 16'h3FFF);
    md(mac_pkg::OP_SET_MODE, mac_pkg::SEL_FRACTION);
    mul(16'h7FFF, 16'h0002, 16'h7FFE);
    op(mac_pkg::OP_MULTIPLY, 16'h7FFF, 16'h0000, HI, mac_pkg::SEL_SIGN_EXTEND);
    note(1'b1, 16'h0002, 16'h7FFE);
    md(mac_pkg::OP_CLEAR_MODE, mac_pkg::SEL_FRACTION);
    md(mac_pkg::OP_SET_MODE, mac_pkg::SEL_SATURATE);
    md(mac_pkg::OP_SET_MODE, mac_pkg::SEL_UNSIGNED);
    idle;
    sts(5'h05);
    wr(mac_pkg::OFS_MASK, 32'h0000_0003);
    add(mac_pkg::OP_ADD, 16'h7FFE, 16'h0005, ONE, 16'h7FFF);
    add(mac_pkg::OP_SUB, 16'h8000, 16'h0001, ONE, 16'h8000);
    idle;
    sts(5'h15);
    repeat (2) @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(mac_pkg::OFS_EVENT, 32'h0000_0003);
    repeat (2) @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0000_0000);
    add(mac_pkg::OP_ADD, 16'h1234, 16'h1000, LO, 16'h2234);
    add(mac_pkg::OP_ADD, 16'h7F00, 16'h1000, HI, 16'h7FFF);
    idle;
    wr(mac_pkg::OFS_STATUS, 32'h0000_0001);
    add(mac_pkg::OP_ADD, 16'h7FFE, 16'h0005, ONE, 16'h8003);
    idle;
    wr(mac_pkg::OFS_STATUS, 32'h0000_0005);
    add(mac_pkg::OP_AND, 16'hFFFF, 16'h8000, ONE, 16'h8000);
    add(mac_pkg::OP_OR, 16'h7FFF, 16'h8000, ONE, 16'hFFFF);
    add(mac_pkg::OP_XOR, 16'h7FFF, 16'hFFFF, ONE, 16'h8000);
    idle;
    sts(5'h05);
    wr(mac_pkg::OFS_STATUS, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      ra = 16'($random(seed));
      rb = 16'($random(seed));
      rs = {1'b0, ra} + {1'b0, rb};
      add(mac_pkg::OP_ADD, ra, rb, ONE, 16'(ra + rb));
    end
    idle;
    rd(mac_pkg::OFS_PRODUCT_HIGH, 32'h0000_7FFE);
    rd(8'h14, 32'h0000_0000);
    chk({31'h0, carryOut}, {31'h0, rs[16]});
    repeat (3) @(negedge ref_clk);
    chk(32'(expQ.size()), 32'h0000_0000);
    chk(32'(wordCnt), 32'(pushed));
    chk({16'h0000, lastWord}, {16'h0000, lastExp});
    testDone;
  end
endmodule
